// >>> aps_switch_time_monitor.sv
// Summary of operation
// RL1 - On SDH/SONET decode received K1/K2 always and flag every change.
// RL2 - Time each reference occurrence; keep running average and maximum.
// RL3 - On PDH/DSn count detected reference occurrences.
// RL4 - SDH/SONET measurement closes after configurable error-free gap.
// RL5 - Threshold in 1 us steps, up to 10000 ms SDH, 4000 ms PDH.
// RL6 - Pass/fail from comparing durations with the threshold.
// RL7 - Any-errors selection makes every listed event a trigger.
// RL8 - SDH any-errors never triggers on LSS or TC-REI.
// RL9 - No LOS on electrical SDH; PDH uses its own event list.
// RL10 - Report min, max, average, threshold and measurement count.
// RL11 - Transmit K1 bits 5-8 carry configured channel 0..15.
// RL12 - Transmit K2 bits 1-4 carry configured channel 0..15.
// RL13 - Ring short/long or linear 1+1/1:n selects request encoding.
// RL14 - Configured request reaches K1/K2 only on explicit apply.
// RL15 - Durations resolved to one microsecond.
//
// The AHB-Lite interface to the registers and the placing of the registers are this design's own decisions.
`default_nettype none
module aps_switch_time_monitor (
   // Clock and reset
   input  wire logic                     sys_clk,
   input  wire logic                     nrst,
   // AHB-Lite slave
   input  wire logic                     hsel,
   input  wire logic [31:0]              haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic      [31:0]              hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   // Line receive side
   input  wire logic [aps_pkg::EV_W-1:0] rxEvents,
   input  wire logic [7:0]               rxK1,
   input  wire logic [7:0]               rxK2,
   input  wire logic                     rxKValid,
   // Line transmit side
   output logic      [7:0]               txK1,
   output logic      [7:0]               txK2,
   // Interrupt
   output logic                          irq
);
   aps_pkg::aps_state_t state_ff, nxt_state;
   logic [4:0]  ctrl_ff;
   logic [4:0]  sel_ff;
   logic [23:0] errFree_ff, thresh_ff, dur_ff, gap_ff, last_ff;
   logic [11:0] req_ff;
   logic [7:0]  k1_ff, k2_ff, txK1_ff, txK2_ff;
   logic [15:0] kChgCnt_ff;
   logic [3:0]  div_ff;
   logic [2:0]  irqStat_ff, irqMask_ff;
   logic        fail_ff, applied_ff, wrPend_ff;
   logic [7:0]  wrAddr_ff;
   logic [31:0] hrdata_ff;
   logic [23:0] minDur, maxDur, avgDur;
   logic [15:0] measCnt;

   // Bus decode
   wire        addrPhase = hsel && htrans[1] && hready;
   wire [7:0]  rAddr     = haddr[7:0];
   wire        wr        = wrPend_ff;
   wire        wrCtrl    = wr && wrAddr_ff == aps_pkg::ADDR_CTRL;
   wire        wrSel     = wr && wrAddr_ff == aps_pkg::ADDR_REFSEL;
   wire        wrErrFree = wr && wrAddr_ff == aps_pkg::ADDR_ERRFREE;
   wire        wrThresh  = wr && wrAddr_ff == aps_pkg::ADDR_THRESH;
   wire        wrReq     = wr && wrAddr_ff == aps_pkg::ADDR_REQ;
   wire        wrIrqStat = wr && wrAddr_ff == aps_pkg::ADDR_IRQSTAT;
   wire        wrIrqMask = wr && wrAddr_ff == aps_pkg::ADDR_IRQMASK;
   wire        applyCmd  = wrCtrl && hwdata[aps_pkg::CTRL_APPLY];
   wire        clrCmd    = wrCtrl && hwdata[aps_pkg::CTRL_CLR];

   wire        run   = ctrl_ff[aps_pkg::CTRL_RUN];
   wire        sdh   = ctrl_ff[aps_pkg::CTRL_SDH];
   wire        elec  = ctrl_ff[aps_pkg::CTRL_ELEC];
   wire        ring  = ctrl_ff[aps_pkg::CTRL_RING];
   wire        alt   = ctrl_ff[aps_pkg::CTRL_ALT];

   // Threshold limit follows the line type
   wire [23:0] thrMax  = sdh ? aps_pkg::THR_MAX_SDH : aps_pkg::THR_MAX_PDH;
   wire [23:0] thrReq  = hwdata[23:0];
   wire [23:0] thrNew  = (thrReq > thrMax) ? thrMax : thrReq; // RL5

   // Reference event selection
   wire [15:0] sdhList = elec ? (aps_pkg::SDH_LIST & ~aps_pkg::LOS_BIT)
                              : aps_pkg::SDH_LIST; // RL9 RL8
   wire [15:0] allowed = sdh ? sdhList : aps_pkg::PDH_LIST; // RL9
   wire [15:0] oneHot  = 16'h0001 << sel_ff[3:0];
   wire [15:0] selMask = (sel_ff == aps_pkg::SEL_ANY) ? allowed // RL7
                                                      : (oneHot & allowed);
   wire        refEvent = |(rxEvents & selMask);

   // Microsecond tick: 1 us resolution keeps three ms decimals exact
   wire        tick    = div_ff == 4'(aps_pkg::TICK_CYC - 1); // RL15
   wire [23:0] durInc  = (dur_ff == aps_pkg::DUR_SAT) ? dur_ff
                                                      : dur_ff + 24'h1;
   wire [23:0] gapInc  = (gap_ff == aps_pkg::DUR_SAT) ? gap_ff
                                                      : gap_ff + 24'h1;
   wire        gapDone = gap_ff >= errFree_ff;

   logic        measDone;
   logic [23:0] measDur;
   always_comb begin
      nxt_state = state_ff;
      measDone  = 1'b0;
      measDur   = dur_ff;
      case (state_ff)
         aps_pkg::ST_IDLE: begin
            if (run && refEvent) nxt_state = aps_pkg::ST_EVT;
         end
         aps_pkg::ST_EVT: begin
            if (!run) begin
               nxt_state = aps_pkg::ST_IDLE;
            end else if (!refEvent && sdh) begin
               nxt_state = aps_pkg::ST_GAP;
            end else if (!refEvent) begin
               nxt_state = aps_pkg::ST_IDLE;
               measDone  = 1'b1; // RL3
            end
         end
         aps_pkg::ST_GAP: begin
            measDur = last_ff;
            if (!run) begin
               nxt_state = aps_pkg::ST_IDLE;
            end else if (refEvent) begin
               nxt_state = aps_pkg::ST_EVT;
            end else if (gapDone) begin
               nxt_state = aps_pkg::ST_IDLE;
               measDone  = 1'b1; // RL4
            end
         end
         default: nxt_state = aps_pkg::ST_IDLE;
      endcase
   end

   wire        measFail = measDone && measDur > thresh_ff; // RL6
   wire        kChange  = sdh && rxKValid &&
                          (rxK1 != k1_ff || rxK2 != k2_ff); // RL1
   wire [2:0]  irqSet   = {measFail, kChange, measDone};
   wire [2:0]  irqClr   = wrIrqStat ? hwdata[2:0] : 3'h0;

   // Transmit encoding from protection configuration
   // Apply may share its write with the mode bits, so take them from it
   wire        ringNow = wrCtrl ? hwdata[aps_pkg::CTRL_RING] : ring;
   wire        altNow  = wrCtrl ? hwdata[aps_pkg::CTRL_ALT] : alt;
   wire [2:0]  k2Mode = ringNow ? aps_pkg::K2_MODE_RING
                                : aps_pkg::K2_MODE_LIN; // RL13
   wire [7:0]  newK1  = {req_ff[3:0], req_ff[7:4]}; // RL11
   wire [7:0]  newK2  = {req_ff[11:8], altNow, k2Mode}; // RL12 RL13

   // Read mux
   wire [31:0] rdCtrl = {27'h0, ctrl_ff};
   wire [31:0] rdStat = {28'h0, applied_ff, state_ff != aps_pkg::ST_IDLE,
                         fail_ff, !fail_ff};
   wire [31:0] rdRxK  = {kChgCnt_ff, k1_ff, k2_ff};
   wire [31:0] rdData =
      (rAddr == aps_pkg::ADDR_CTRL)    ? rdCtrl :
      (rAddr == aps_pkg::ADDR_REFSEL)  ? {27'h0, sel_ff} :
      (rAddr == aps_pkg::ADDR_ERRFREE) ? {8'h0, errFree_ff} :
      (rAddr == aps_pkg::ADDR_THRESH)  ? {8'h0, thresh_ff} : // RL10
      (rAddr == aps_pkg::ADDR_REQ)     ? {20'h0, req_ff} :
      (rAddr == aps_pkg::ADDR_STATUS)  ? rdStat :
      (rAddr == aps_pkg::ADDR_MIN)     ? {8'h0, minDur} : // RL10
      (rAddr == aps_pkg::ADDR_MAX)     ? {8'h0, maxDur} :
      (rAddr == aps_pkg::ADDR_AVG)     ? {8'h0, avgDur} :
      (rAddr == aps_pkg::ADDR_COUNT)   ? {16'h0, measCnt} :
      (rAddr == aps_pkg::ADDR_RXK)     ? rdRxK :
      (rAddr == aps_pkg::ADDR_TXK)     ? {16'h0, txK1_ff, txK2_ff} :
      (rAddr == aps_pkg::ADDR_IRQSTAT) ? {29'h0, irqStat_ff} :
      (rAddr == aps_pkg::ADDR_IRQMASK) ? {29'h0, irqMask_ff} :
                                         32'h0;

   // Bus phase tracking; zero wait states so reads are latched early
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wrPend_ff <= 1'b0;
         wrAddr_ff <= 8'h00;
         hrdata_ff <= 32'h0;
      end else begin
         wrPend_ff <= addrPhase && hwrite;
         if (addrPhase) wrAddr_ff <= rAddr;
         if (addrPhase && !hwrite) hrdata_ff <= rdData;
      end
   end

   // Configuration registers
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_ff    <= aps_pkg::CTRL_RST;
         sel_ff     <= aps_pkg::SEL_RST;
         errFree_ff <= aps_pkg::ERRFREE_RST;
         thresh_ff  <= aps_pkg::THR_RST;
         req_ff     <= 12'h000;
         irqMask_ff <= 3'h0;
      end else begin
         if (wrCtrl) ctrl_ff <= hwdata[4:0];
         if (wrSel) sel_ff <= hwdata[4:0];
         if (wrErrFree) errFree_ff <= hwdata[23:0]; // RL4
         if (wrThresh) thresh_ff <= thrNew; // RL5
         if (wrReq) req_ff <= hwdata[11:0];
         if (wrIrqMask) irqMask_ff <= hwdata[2:0];
      end
   end

   // Measurement timers
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_ff <= aps_pkg::ST_IDLE;
         div_ff   <= 4'h0;
         dur_ff   <= 24'h0;
         gap_ff   <= 24'h0;
         last_ff  <= 24'h0;
      end else begin
         state_ff <= nxt_state;
         div_ff   <= tick ? 4'h0 : div_ff + 4'h1;
         if (state_ff == aps_pkg::ST_IDLE) begin
            dur_ff <= 24'h0;
         end else if (tick) begin
            dur_ff <= durInc; // RL2 RL15
         end
         if (state_ff == aps_pkg::ST_EVT && nxt_state == aps_pkg::ST_GAP) begin
            last_ff <= dur_ff;
            gap_ff  <= 24'h0;
         end else if (state_ff == aps_pkg::ST_GAP && tick) begin
            gap_ff  <= gapInc; // RL4
         end
      end
   end

   // Result, protocol and interrupt state; a set beats a same-cycle clear
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         fail_ff    <= 1'b0;
         k1_ff      <= 8'h00;
         k2_ff      <= 8'h00;
         kChgCnt_ff <= 16'h0;
         txK1_ff    <= 8'h00;
         txK2_ff    <= 8'h00;
         applied_ff <= 1'b0;
         irqStat_ff <= 3'h0;
      end else begin
         if (measFail) begin
            fail_ff <= 1'b1; // RL6
         end else if (clrCmd) begin
            fail_ff <= 1'b0;
         end
         if (kChange) begin
            k1_ff      <= rxK1; // RL1
            k2_ff      <= rxK2;
            kChgCnt_ff <= kChgCnt_ff + 16'h1;
         end
         if (applyCmd) begin
            txK1_ff    <= newK1; // RL14
            txK2_ff    <= newK2;
            applied_ff <= 1'b1;
         end else if (wrReq) begin
            applied_ff <= 1'b0;
         end
         irqStat_ff <= (irqStat_ff & ~irqClr) | irqSet;
      end
   end

   aps_stat_unit u_stat (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .clr         (clrCmd),
      .sampleValid (measDone),
      .sampleDur   (measDur),
      .minDur      (minDur),
      .maxDur      (maxDur),
      .avgDur      (avgDur),
      .count       (measCnt)
   );

   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign txK1      = txK1_ff;
   assign txK2      = txK2_ff;
   assign irq       = |(irqStat_ff & irqMask_ff);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_tx_apply_only: assert property ( // RL14
      $changed(txK1_ff) || $changed(txK2_ff) |-> $past(applyCmd))
      else $error("tx K bytes changed without apply");
   a_tick_period: assert property (tick |=> !tick ##9 tick) // RL15
      else $error("microsecond tick period wrong");
   a_no_lss_tcrei: assert property ( // RL8
      sdh && (rxEvents & ~16'hC000) == 16'h0 |-> !refEvent)
      else $error("LSS or TC-REI triggered a reference event");
   a_no_los_elec: assert property ( // RL9
      sdh && elec && (rxEvents & ~aps_pkg::LOS_BIT) == 16'h0 |-> !refEvent)
      else $error("LOS triggered on electrical interface");
   a_count_step: assert property ( // RL3
      measDone && !clrCmd && measCnt != 16'hFFFF
      |=> measCnt == $past(measCnt) + 16'h1)
      else $error("measurement count did not advance");
   a_max_update: assert property ( // RL2
      measDone && !clrCmd && measDur > maxDur |=> maxDur == $past(measDur))
      else $error("maximum duration not updated");
   a_fail_flag: assert property (measFail |=> fail_ff ##1 fail_ff) // RL6
      else $error("fail flag not held after long event");
   a_gap_close: assert property ( // RL4
      measDone && sdh |-> state_ff == aps_pkg::ST_GAP && gapDone)
      else $error("SDH measurement closed before error-free gap");
   a_k_decode: assert property (kChange |=> k1_ff == $past(rxK1) // RL1
      && k2_ff == $past(rxK2) && irqStat_ff[aps_pkg::IRQ_KCHG])
      else $error("K byte change not captured");
   a_thresh_limit: assert property (wrThresh |=> thresh_ff <= thrMax) // RL5
      else $error("threshold above range");
   c_meas_done: cover property (measDone);
   c_meas_fail: cover property (measFail);
   c_k_change: cover property (kChange);
   c_apply: cover property (applyCmd ##1 txK1_ff != 8'h00);
endmodule : aps_switch_time_monitor
`default_nettype wire

// >>> aps_pkg.sv
`default_nettype none
package aps_pkg;
   // Bus map (byte addresses)
   localparam logic [7:0] ADDR_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_REFSEL  = 8'h04;
   localparam logic [7:0] ADDR_ERRFREE = 8'h08;
   localparam logic [7:0] ADDR_THRESH  = 8'h0C;
   localparam logic [7:0] ADDR_REQ     = 8'h10;
   localparam logic [7:0] ADDR_STATUS  = 8'h14;
   localparam logic [7:0] ADDR_MIN     = 8'h18;
   localparam logic [7:0] ADDR_MAX     = 8'h1C;
   localparam logic [7:0] ADDR_AVG     = 8'h20;
   localparam logic [7:0] ADDR_COUNT   = 8'h24;
   localparam logic [7:0] ADDR_RXK     = 8'h28;
   localparam logic [7:0] ADDR_TXK     = 8'h2C;
   localparam logic [7:0] ADDR_IRQSTAT = 8'h30;
   localparam logic [7:0] ADDR_IRQMASK = 8'h34;
   // CTRL fields
   localparam int CTRL_RUN   = 0;
   localparam int CTRL_SDH   = 1;
   localparam int CTRL_ELEC  = 2;
   localparam int CTRL_RING  = 3;
   localparam int CTRL_ALT   = 4;
   localparam int CTRL_APPLY = 5;
   localparam int CTRL_CLR   = 6;
   localparam logic [4:0] CTRL_RST = 5'h02;
   // Reference select
   localparam logic [4:0] SEL_ANY  = 5'h1F;
   localparam logic [4:0] SEL_RST  = 5'h00;
   // Event vector bit positions and selectable lists
   localparam int EV_W     = 16;
   localparam int EV_LOS   = 0;
   localparam int EV_LSS   = 14;
   localparam int EV_TCREI = 15;
   localparam logic [15:0] SDH_LIST = 16'h3FFF;
   localparam logic [15:0] PDH_LIST = 16'h00FF;
   localparam logic [15:0] LOS_BIT  = 16'h0001;
   // Durations in microseconds
   localparam int DUR_W = 24;
   localparam int CNT_W = 16;
   localparam int SUM_W = DUR_W + CNT_W;
   localparam logic [23:0] THR_MAX_SDH = 24'h989680; // 10000.000 ms
   localparam logic [23:0] THR_MAX_PDH = 24'h3D0900; // 4000.000 ms
   localparam logic [23:0] THR_RST     = 24'h00C350; // 50.000 ms
   localparam logic [23:0] ERRFREE_RST = 24'h0003E8; // 1 ms
   localparam logic [23:0] DUR_SAT     = 24'hFFFFFF;
   // Timing
   localparam int CLK_NS  = 100;
   localparam int TICK_NS = 1000;
   localparam int TICK_CYC = TICK_NS / CLK_NS;
   // IRQ bits
   localparam int IRQ_W    = 3;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_KCHG = 1;
   localparam int IRQ_FAIL = 2;
   // K2 mode bits
   localparam logic [2:0] K2_MODE_RING = 3'h0;
   localparam logic [2:0] K2_MODE_LIN  = 3'h4;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EVT  = 3'b010,
      ST_GAP  = 3'b100
   } aps_state_t;
endpackage : aps_pkg
`default_nettype wire

// >>> aps_stat_unit.sv
`default_nettype none
module aps_stat_unit (
   // Clock and reset
   input  wire logic                      sys_clk,
   input  wire logic                      nrst,
   // Samples
   input  wire logic                      clr,
   input  wire logic                      sampleValid,
   input  wire logic [aps_pkg::DUR_W-1:0] sampleDur,
   // Results
   output logic      [aps_pkg::DUR_W-1:0] minDur,
   output logic      [aps_pkg::DUR_W-1:0] maxDur,
   output logic      [aps_pkg::DUR_W-1:0] avgDur,
   output logic      [aps_pkg::CNT_W-1:0] count
);
   logic [aps_pkg::DUR_W-1:0] min_ff, max_ff, avg_ff;
   logic [aps_pkg::CNT_W-1:0] cnt_ff, div_ff;
   logic [aps_pkg::SUM_W-1:0] sum_ff, num_ff;
   logic [aps_pkg::CNT_W:0]   rem_ff;
   logic [5:0]                step_ff;
   logic                      busy_ff;
   wire  [aps_pkg::CNT_W-1:0] nxtCnt = (cnt_ff == 16'hFFFF) ? cnt_ff
                                                            : cnt_ff + 16'h1;
   wire  [aps_pkg::SUM_W-1:0] nxtSum = sum_ff + {16'h0, sampleDur};
   wire  [aps_pkg::CNT_W:0]   remSh  = {rem_ff[aps_pkg::CNT_W-1:0],
                                        num_ff[aps_pkg::SUM_W-1]};
   wire                       qBit   = remSh >= {1'b0, div_ff};
   // Serial divide keeps the average cheap; it settles 40 cycles later
   always_ff @(posedge sys_clk) begin
      if (!nrst || clr) begin
         min_ff  <= 24'hFFFFFF;
         max_ff  <= 24'h000000;
         avg_ff  <= 24'h000000;
         cnt_ff  <= 16'h0000;
         sum_ff  <= 40'h0;
         num_ff  <= 40'h0;
         rem_ff  <= 17'h0;
         div_ff  <= 16'h0;
         step_ff <= 6'h0;
         busy_ff <= 1'b0;
      end else if (sampleValid) begin
         if (sampleDur < min_ff) min_ff <= sampleDur;
         if (sampleDur > max_ff) max_ff <= sampleDur; // RL2
         cnt_ff  <= nxtCnt; // RL3
         sum_ff  <= nxtSum;
         num_ff  <= nxtSum;
         div_ff  <= nxtCnt;
         rem_ff  <= 17'h0;
         step_ff <= 6'd40;
         busy_ff <= 1'b1;
      end else if (busy_ff) begin
         rem_ff  <= qBit ? remSh - {1'b0, div_ff} : remSh;
         num_ff  <= {num_ff[aps_pkg::SUM_W-2:0], qBit};
         step_ff <= step_ff - 6'h1;
         if (step_ff == 6'h1) begin
            busy_ff <= 1'b0;
            avg_ff  <= {num_ff[aps_pkg::DUR_W-2:0], qBit}; // RL2
         end
      end
   end
   assign minDur = min_ff;
   assign maxDur = max_ff;
   assign avgDur = avg_ff;
   assign count  = cnt_ff;
endmodule : aps_stat_unit
`default_nettype wire

// >>> aps_line_model.sv
`default_nettype none
module aps_line_model (
   // Clock
   input  wire logic                     sys_clk,
   // Line toward the monitor
   output logic      [aps_pkg::EV_W-1:0] rxEvents,
   output logic      [7:0]               rxK1,
   output logic      [7:0]               rxK2,
   output logic                          rxKValid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      rxEvents = 16'h0000;
      rxK1     = 8'h00;
      rxK2     = 8'h00;
      rxKValid = 1'b0;
   end
   // Alarm level for hi cycles, then quiet for lo cycles
   task automatic burst(input logic [15:0] bits, input int hi, lo);
      @(posedge sys_clk);
      rxEvents <= bits;
      repeat (hi) @(posedge sys_clk);
      rxEvents <= 16'h0000;
      repeat (lo) @(posedge sys_clk);
   endtask : burst
   // Bytes mean nothing off the strobe, so they are inverted there
   task automatic sendK(input logic [7:0] k1, k2);
      @(posedge sys_clk);
      rxK1 <= k1;
      rxK2 <= k2;
      rxKValid <= 1'b1;
      @(posedge sys_clk);
      rxK1 <= ~k1;
      rxK2 <= ~k2;
      rxKValid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : sendK
endmodule : aps_line_model
`default_nettype wire

// >>> aps_switch_time_monitor_test.sv
`default_nettype none
module aps_switch_time_monitor_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire  [15:0] rxEvents;
   wire  [7:0]  rxK1;
   wire  [7:0]  rxK2;
   wire         rxKValid;
   wire  [7:0]  txK1;
   wire  [7:0]  txK2;
   wire         irq;
   int          errTotal = 0;
   int          compares = 0;
   logic [31:0] q;
   always #50 sys_clk = ~sys_clk;
   aps_switch_time_monitor i_dut (
      .sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .rxEvents(rxEvents), .rxK1(rxK1), .rxK2(rxK2),
      .rxKValid(rxKValid), .txK1(txK1), .txK2(txK2), .irq(irq));
   aps_line_model i_line (
      .sys_clk(sys_clk), .rxEvents(rxEvents), .rxK1(rxK1),
      .rxK2(rxK2), .rxKValid(rxKValid));
   task automatic summarize();
      if (errTotal == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         errTotal++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Durations are counted in whole ticks, so one microsecond of slack
   task automatic near(input string n, input logic [31:0] e, g);
      compares++;
      if ((^g === 1'bx) || g + 1 < e || g > e + 1) begin
         errTotal++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : near
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
      // Outputs launched by the write edge are looked at once settled
      @(negedge sys_clk);
   endtask : wr
   task automatic cr(input string n, input logic [7:0] a,
                     input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(n, e, r);
   endtask : cr
   task automatic t_reset();
      cr("ctrl", aps_pkg::ADDR_CTRL, 32'h00000002);
      cr("refsel", aps_pkg::ADDR_REFSEL, 32'h00000000);
      cr("errfree", aps_pkg::ADDR_ERRFREE, 32'h000003E8);
      cr("thresh", aps_pkg::ADDR_THRESH, 32'h0000C350);
      cr("min", aps_pkg::ADDR_MIN, 32'h00FFFFFF);
      cr("count", aps_pkg::ADDR_COUNT, 32'h00000000);
      cr("txk", aps_pkg::ADDR_TXK, 32'h00000000);
      cr("unmapped", 8'h3C, 32'h00000000);
      chk("irq", 32'h0, {31'h0, irq});
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask : t_reset
   task automatic t_clamp();
      wr(aps_pkg::ADDR_THRESH, 32'h00FFFFFF);
      cr("thr sdh", aps_pkg::ADDR_THRESH, 32'h00989680);
      wr(aps_pkg::ADDR_THRESH, 32'h00000000);
      cr("thr zero", aps_pkg::ADDR_THRESH, 32'h00000000);
      wr(aps_pkg::ADDR_CTRL, 32'h00000000);
      wr(aps_pkg::ADDR_THRESH, 32'h00FFFFFF);
      cr("thr pdh", aps_pkg::ADDR_THRESH, 32'h003D0900);
   endtask : t_clamp
   task automatic t_sdh();
      wr(aps_pkg::ADDR_CTRL, 32'h00000043);
      wr(aps_pkg::ADDR_ERRFREE, 32'h00000005);
      wr(aps_pkg::ADDR_THRESH, 32'h0000001E);
      wr(aps_pkg::ADDR_IRQMASK, 32'h00000007);
      wr(aps_pkg::ADDR_CTRL, 32'h00000003);
      // A short clear inside the gap must not split the measurement
      i_line.burst(16'h0001, 100, 20);
      i_line.burst(16'h0001, 100, 150);
      i_line.burst(16'h0001, 400, 150);
      xfer(1'b0, aps_pkg::ADDR_MIN, 32'h0, q);
      near("min", 32'd22, q);
      xfer(1'b0, aps_pkg::ADDR_MAX, 32'h0, q);
      near("max", 32'd40, q);
      xfer(1'b0, aps_pkg::ADDR_AVG, 32'h0, q);
      near("avg", 32'd31, q);
      cr("count", aps_pkg::ADDR_COUNT, 32'h00000002);
      xfer(1'b0, aps_pkg::ADDR_STATUS, 32'h0, q);
      chk("fail", 32'h2, q & 32'h3);
      chk("irq set", 32'h1, {31'h0, irq});
      wr(aps_pkg::ADDR_IRQSTAT, 32'h00000007);
      chk("irq clr", 32'h0, {31'h0, irq});
   endtask : t_sdh
   task automatic t_any();
      wr(aps_pkg::ADDR_CTRL, 32'h00000043);
      wr(aps_pkg::ADDR_CTRL, 32'h00000003);
      wr(aps_pkg::ADDR_REFSEL, 32'h0000001F);
      i_line.burst(16'h4000, 50, 100);
      i_line.burst(16'h8000, 50, 100);
      cr("lss tcrei", aps_pkg::ADDR_COUNT, 32'h00000000);
      i_line.burst(16'h2000, 50, 100);
      cr("any", aps_pkg::ADDR_COUNT, 32'h00000001);
      wr(aps_pkg::ADDR_CTRL, 32'h00000047);
      wr(aps_pkg::ADDR_CTRL, 32'h00000007);
      wr(aps_pkg::ADDR_REFSEL, 32'h00000000);
      i_line.burst(16'h0001, 50, 100);
      cr("elec los", aps_pkg::ADDR_COUNT, 32'h00000000);
   endtask : t_any
   task automatic t_pdh();
      wr(aps_pkg::ADDR_IRQMASK, 32'h00000000);
      wr(aps_pkg::ADDR_CTRL, 32'h00000041);
      wr(aps_pkg::ADDR_CTRL, 32'h00000001);
      wr(aps_pkg::ADDR_THRESH, 32'h00002710);
      wr(aps_pkg::ADDR_REFSEL, 32'h0000001F);
      i_line.sendK(8'h11, 8'h22);
      i_line.burst(16'h0200, 50, 30);
      cr("pdh list", aps_pkg::ADDR_COUNT, 32'h00000000);
      for (int i = 0; i < 3; i++) begin
         i_line.burst(16'h0080, 50, 30);
      end
      cr("pdh count", aps_pkg::ADDR_COUNT, 32'h00000003);
      xfer(1'b0, aps_pkg::ADDR_MAX, 32'h0, q);
      near("pdh max", 32'd5, q);
      xfer(1'b0, aps_pkg::ADDR_STATUS, 32'h0, q);
      chk("pass", 32'h1, q & 32'h3);
      xfer(1'b0, aps_pkg::ADDR_IRQSTAT, 32'h0, q);
      chk("done", 32'h1, q & 32'h1);
      chk("masked", 32'h0, {31'h0, irq});
   endtask : t_pdh
   task automatic t_k();
      wr(aps_pkg::ADDR_CTRL, 32'h00000003);
      i_line.sendK(8'hA5, 8'h3C);
      i_line.sendK(8'hA5, 8'h3C);
      i_line.sendK(8'h5A, 8'h3C);
      cr("rxk", aps_pkg::ADDR_RXK, 32'h00025A3C);
      xfer(1'b0, aps_pkg::ADDR_IRQSTAT, 32'h0, q);
      chk("kchg", 32'h2, q & 32'h2);
   endtask : t_k
   task automatic t_tx();
      logic [15:0] pv;
      logic [3:0]  c;
      logic [3:0]  a;
      logic [3:0]  b;
      pv = 16'h0000;
      for (int i = 0; i < 4; i++) begin
         c = 4'hF - 4'(i);
         a = 4'(i * 5);
         b = 4'hF - a;
         wr(aps_pkg::ADDR_REQ, {20'h0, b, a, c});
         chk("hold", {16'h0, pv}, {16'h0, txK1, txK2});
         wr(aps_pkg::ADDR_CTRL, {26'h0, 1'b1, 1'(i), 1'(i >> 1), 3'h3});
         pv = {c, a, b, 1'(i), (i >> 1) ? 3'h0 : 3'h4};
         chk("txk", {16'h0, pv}, {16'h0, txK1, txK2});
         xfer(1'b0, aps_pkg::ADDR_STATUS, 32'h0, q);
         chk("applied", 32'h8, q & 32'h8);
      end
   endtask : t_tx
   initial begin
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      t_reset();
      t_clamp();
      t_sdh();
      t_any();
      t_pdh();
      t_k();
      t_tx();
      summarize();
   end
   // Whole run needs some 2100 cycles
   initial begin
      #(40000 * 100);
      errTotal++;
      summarize();
   end
endmodule : aps_switch_time_monitor_test
`default_nettype wire
